// ---- hdl/rsm_pkg.sv ----
// Constants for the reset sequence manager
//
// Functional notes
// - Pin, low-voltage and watchdog sources all hold the reset pin low during delay.
// - Reset runs active phase, 256/4096-clock delay by option, then vector fetch.
// - Vector fetch phase lasts exactly two clock cycles.
// - Program counter loads from the top two bytes of memory.
// - Resonator oscillator keeps running during reset.
// - Clock source option picks external, four resonator ranges or internal RC.
// - External reset detection is asynchronous and works without a clock.
// - Reset pin is an input and an open-drain output with weak pull-up.
// - Recognised pin pulse is stretched to at least the minimum output width.
// - Watchdog underflow drives reset pin low for at least minimum width.
// - While supply is below threshold, a static reset holds the pin low.
// - Low-voltage reset drives the pin low to reset other board devices.
// - Low-voltage detector enabled by option; threshold low, medium or high.
// - Aux detector output is a real-time read-only status flag.
// - Aux detector flag and interrupt inert unless low-voltage detector enabled.
// - Source select 0 watches main supply, 1 watches the external sense pin.
// - With enable set each flag toggle raises a request, cleared on handler entry.
// - Watchdog flag set by watchdog reset, cleared by writing zero or low-voltage reset.
// - Low-voltage flag set by low-voltage reset, cleared only by writing zero.
package rsm_pkg;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int RSM_DELAY_SHORT = 256;
	localparam int RSM_DELAY_LONG = 4096;
	localparam int RSM_FETCH_CYCLES = 2;
	localparam int RSM_CLK_MHZ = 25;
	localparam int RSM_PULSE_MIN_NS = 20000;
	localparam int RSM_PULSE_CYCLES = (RSM_PULSE_MIN_NS * RSM_CLK_MHZ + 999) / 1000;
	localparam int RSM_CNT_W = 13;
	// ------------------------------------------------------------
	// Vector and option encodings
	// ------------------------------------------------------------
	localparam logic [15:0] RSM_VEC_HI_ADDR = 16'hFFFE;
	localparam logic [15:0] RSM_VEC_LO_ADDR = 16'hFFFF;
	localparam logic [2:0] RSM_CLK_EXT = 3'h0;
	localparam logic [2:0] RSM_CLK_RES0 = 3'h1;
	localparam logic [2:0] RSM_CLK_RES3 = 3'h4;
	localparam logic [2:0] RSM_CLK_RC = 3'h5;
	typedef enum logic [1:0] {RSM_TH_LOW, RSM_TH_MED, RSM_TH_HIGH, RSM_TH_RSVD} rsm_thresh_e;
	// Status byte field positions
	localparam int RSM_BIT_SRC = 7;
	localparam int RSM_BIT_IE = 6;
	localparam int RSM_BIT_AUXF = 5;
	localparam int RSM_BIT_LVRF = 4;
	localparam int RSM_BIT_WDRF = 0;
endpackage : rsm_pkg

// ---- hdl/rsm_sync.sv ----
// Two-flop synchroniser bank
`timescale 1ns/10ps
`default_nettype none
module rsm_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	// Meta stage feeds only the output stage
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta <= INIT;
			q <= INIT;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : rsm_sync
`default_nettype wire

// ---- hdl/rsm_top.sv ----
// Reset sequencer with system integrity flags
`timescale 1ns/10ps
`default_nettype none
module rsm_top
	import rsm_pkg::*;
#(
	parameter int DELAY_LONG = rsm_pkg::RSM_DELAY_LONG
) (
	// Clock and power-on reset
	input wire logic clk,
	input wire logic arst_n,
	// Nonvolatile options
	input wire logic opt_long_delay,
	input wire logic opt_lvd_enable,
	input wire rsm_pkg::rsm_thresh_e opt_lvd_thresh,
	input wire logic [2:0] opt_clk_src,
	// Reset pin, open drain
	input wire logic rst_pin_in,
	output logic rst_pin_out,
	output logic rst_pin_oe,
	// Sources
	input wire logic lvd_below,
	input wire logic dog_underflow,
	input wire logic aux_cmp_supply,
	input wire logic aux_cmp_sense,
	// Control bits from software
	input wire logic aux_source_select,
	input wire logic aux_irq_enable,
	input wire logic flag_wr,
	input wire logic [7:0] flag_wdata,
	input wire logic irq_ack,
	// Status
	output logic aux_detect_flag,
	output logic lowv_reset_flag,
	output logic dog_reset_flag,
	output logic [7:0] integrity_ctrl_status,
	output logic aux_irq,
	// CPU side
	output logic cpu_reset,
	output logic vec_fetch,
	output logic [15:0] vec_addr,
	output logic osc_run,
	output logic [1:0] lvd_thresh_sel,
	output logic [2:0] osc_mode,
	output logic sequencing
);
	initial begin
		if (DELAY_LONG < RSM_DELAY_SHORT || DELAY_LONG >= (1 << RSM_CNT_W))
			$error("DELAY_LONG out of range");
	end

	typedef enum logic [2:0] {RSM_ACTIVE, RSM_DELAY, RSM_FETCH, RSM_RUN} rsm_state_e;

	// ------------------------------------------------------------
	// Input synchronisation
	// ------------------------------------------------------------
	logic [3:0] sync_q;
	logic pin_low, lvd_s, aux_sup_s, aux_sen_s;
	logic pin_seen;
	logic [2:0] own_hist;
	logic own_mask;
	// Pin recognition latch is carried, not the raw pin, so short pulses survive
	rsm_sync #(.W(4), .INIT(4'h1)) u_sync (
		.clk(clk),
		.arst_n(arst_n),
		.d({aux_cmp_sense, aux_cmp_supply, lvd_below, pin_seen}),
		.q(sync_q)
	);

	// Last three cycles of own pull-down, the latch plus sync latency
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			own_hist <= 3'h7;
		end else begin
			own_hist <= {own_hist[1:0], rst_pin_oe};
		end
	end

	// Own pull-down reads back as pin low; hide it so it cannot hold us in reset.
	// A pin pulse wholly inside our own pull-down is therefore not seen.
	assign own_mask = rst_pin_oe | (|own_hist);
	assign pin_low = sync_q[0] & ~own_mask;
	assign lvd_s = sync_q[1] & opt_lvd_enable;
	assign aux_sup_s = sync_q[2];
	assign aux_sen_s = sync_q[3];

	// ------------------------------------------------------------
	// Asynchronous pin capture
	// ------------------------------------------------------------
	logic pin_seen_clr;
	// Pin low sets the latch with no clock running, even in halt
	always_ff @(posedge clk or negedge arst_n or negedge rst_pin_in) begin
		if (!arst_n) begin
			pin_seen <= 1'b0;
		end else if (!rst_pin_in) begin
			pin_seen <= 1'b1;
		end else if (pin_seen_clr) begin
			pin_seen <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Output pulse stretcher
	// ------------------------------------------------------------
	localparam int PW = $clog2(RSM_PULSE_CYCLES + 1);
	logic [PW-1:0] pulse_cnt;
	logic pulse_trig;
	assign pulse_trig = pin_low | dog_underflow;
	// Reload on each trigger, count down to release
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pulse_cnt <= PW'(RSM_PULSE_CYCLES);
		end else if (pulse_trig) begin
			pulse_cnt <= PW'(RSM_PULSE_CYCLES);
		end else if (pulse_cnt != '0) begin
			pulse_cnt <= pulse_cnt - 1'b1;
		end
	end
	// Drop the latch once the synchroniser carries it; a held pin sets it again
	assign pin_seen_clr = pin_seen & sync_q[0];

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	rsm_state_e state;
	logic [RSM_CNT_W-1:0] cnt;
	logic src_active;
	logic [RSM_CNT_W-1:0] delay_last;
	assign src_active = lvd_s | (pulse_cnt != '0) | pin_low;
	assign delay_last = opt_long_delay ? RSM_CNT_W'(DELAY_LONG - 1) : RSM_CNT_W'(RSM_DELAY_SHORT - 1);

	// Active, delay, fetch, run; any source restarts from active
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= RSM_ACTIVE;
			cnt <= '0;
		end else if (src_active || dog_underflow) begin
			state <= RSM_ACTIVE;
			cnt <= '0;
		end else begin
			case (state)
				RSM_ACTIVE: begin
					state <= RSM_DELAY;
					cnt <= '0;
				end
				RSM_DELAY: begin
					if (cnt == delay_last) begin
						state <= RSM_FETCH;
						cnt <= '0;
					end else begin
						cnt <= cnt + 1'b1;
					end
				end
				RSM_FETCH: begin
					if (cnt == RSM_CNT_W'(RSM_FETCH_CYCLES - 1)) begin
						state <= RSM_RUN;
					end else begin
						cnt <= cnt + 1'b1;
					end
				end
				RSM_RUN: begin
					cnt <= '0;
				end
				default: begin
					state <= RSM_ACTIVE;
				end
			endcase
		end
	end

	// Pin pulled low through active and delay phases
	assign rst_pin_out = 1'b0;
	assign rst_pin_oe = (state == RSM_ACTIVE) | (state == RSM_DELAY) | lvd_s;
	assign cpu_reset = (state != RSM_RUN);
	assign sequencing = (state != RSM_RUN);
	assign vec_fetch = (state == RSM_FETCH);
	// Fetch high byte then low byte of the vector
	assign vec_addr = (cnt[0]) ? RSM_VEC_LO_ADDR : RSM_VEC_HI_ADDR;
	assign osc_run = (opt_clk_src >= RSM_CLK_RES0) && (opt_clk_src <= RSM_CLK_RES3) ? 1'b1 : 1'b1;
	assign osc_mode = (opt_clk_src > RSM_CLK_RC) ? RSM_CLK_EXT : opt_clk_src;
	assign lvd_thresh_sel = (opt_lvd_thresh == RSM_TH_RSVD) ? 2'(RSM_TH_HIGH) : 2'(opt_lvd_thresh);

	// ------------------------------------------------------------
	// Auxiliary detector flag and interrupt
	// ------------------------------------------------------------
	logic next_aux;
	logic aux_prev;
	assign next_aux = opt_lvd_enable & (aux_source_select ? aux_sen_s : aux_sup_s);

	// Real-time flag, toggle sets pending request
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			aux_detect_flag <= 1'b0;
			aux_prev <= 1'b0;
			aux_irq <= 1'b0;
		end else begin
			aux_detect_flag <= next_aux;
			aux_prev <= aux_detect_flag;
			if (aux_irq_enable && opt_lvd_enable && (aux_detect_flag != aux_prev)) begin
				aux_irq <= 1'b1;
			end else if (irq_ack || !aux_irq_enable || !opt_lvd_enable) begin
				aux_irq <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Reset cause flags; set wins over software clear
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lowv_reset_flag <= 1'b0;
			dog_reset_flag <= 1'b0;
		end else begin
			if (lvd_s) begin
				lowv_reset_flag <= 1'b1;
			end else if (flag_wr && !flag_wdata[RSM_BIT_LVRF]) begin
				lowv_reset_flag <= 1'b0;
			end
			if (dog_underflow) begin
				dog_reset_flag <= 1'b1;
			end else if (lvd_s || (flag_wr && !flag_wdata[RSM_BIT_WDRF])) begin
				dog_reset_flag <= 1'b0;
			end
		end
	end

	// Status byte image
	always_comb begin
		integrity_ctrl_status = 8'h00;
		integrity_ctrl_status[RSM_BIT_SRC] = aux_source_select;
		integrity_ctrl_status[RSM_BIT_IE] = aux_irq_enable;
		integrity_ctrl_status[RSM_BIT_AUXF] = aux_detect_flag;
		integrity_ctrl_status[RSM_BIT_LVRF] = lowv_reset_flag;
		integrity_ctrl_status[RSM_BIT_WDRF] = dog_reset_flag;
	end
endmodule : rsm_top
`default_nettype wire

// ---- testbench/rsm_checker.sv ----
// Assertion checker for the reset sequencer
`timescale 1ns/10ps
`default_nettype none
module rsm_checker
	import rsm_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Inputs watched
	input wire logic opt_lvd_enable,
	input wire logic lvd_below,
	input wire logic dog_underflow,
	input wire logic aux_source_select,
	input wire logic aux_irq_enable,
	input wire logic flag_wr,
	input wire logic [7:0] flag_wdata,
	input wire logic irq_ack,
	// Outputs watched
	input wire logic rst_pin_oe,
	input wire logic aux_detect_flag,
	input wire logic lowv_reset_flag,
	input wire logic dog_reset_flag,
	input wire logic [7:0] integrity_ctrl_status,
	input wire logic aux_irq,
	input wire logic cpu_reset,
	input wire logic vec_fetch,
	input wire logic [15:0] vec_addr
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	logic [15:0] run;
	// Length of the current pin pull-down
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			run <= 16'h0000;
		else
			run <= rst_pin_oe ? run + 16'h0001 : 16'h0000;
	end
	sequence s_fetch;
		vec_fetch && vec_addr == RSM_VEC_HI_ADDR ##1 vec_fetch && vec_addr == RSM_VEC_LO_ADDR;
	endsequence
	sequence s_low_held;
		(opt_lvd_enable && lvd_below)[*4];
	endsequence
	chk_fetch_pair: assert property ($rose(vec_fetch) |-> s_fetch ##1 !vec_fetch && !cpu_reset) else $error("fetch");
	chk_oe_fetch: assert property ($fell(rst_pin_oe) |-> $rose(vec_fetch)) else $error("phase order");
	chk_pulse_width: assert property ($fell(rst_pin_oe) |-> run >= RSM_PULSE_CYCLES) else $error("short pulse");
	chk_dog_pull: assert property (dog_underflow |=> rst_pin_oe) else $error("dog pull");
	chk_lvd_hold: assert property (s_low_held |-> rst_pin_oe) else $error("lvd hold");
	chk_status_map: assert property (integrity_ctrl_status == {aux_source_select, aux_irq_enable,
		aux_detect_flag, lowv_reset_flag, 3'h0, dog_reset_flag}) else $error("status");
	chk_aux_inert: assert property ((!opt_lvd_enable)[*5] |-> !aux_detect_flag && !aux_irq) else $error("inert");
	chk_irq_raise: assert property (opt_lvd_enable && aux_irq_enable && !irq_ack && $changed(aux_detect_flag)
		|=> aux_irq || !aux_irq_enable) else $error("irq raise");
	chk_irq_ack: assert property (irq_ack && !$changed(aux_detect_flag) |=> !aux_irq) else $error("irq ack");
	chk_lowv_keep: assert property (opt_lvd_enable && lowv_reset_flag && !(flag_wr && !flag_wdata[RSM_BIT_LVRF])
		|=> lowv_reset_flag) else $error("lowv kept");
endmodule : rsm_checker
bind rsm_top rsm_checker u_chk (.clk, .arst_n, .opt_lvd_enable, .lvd_below, .dog_underflow, .aux_source_select,
	.aux_irq_enable, .flag_wr, .flag_wdata, .irq_ack, .rst_pin_oe, .aux_detect_flag, .lowv_reset_flag,
	.dog_reset_flag, .integrity_ctrl_status, .aux_irq, .cpu_reset, .vec_fetch, .vec_addr);
`default_nettype wire

// ---- testbench/rsm_board.sv ----
// Board model: external reset circuit on the open-drain pin
`timescale 1ns/10ps
`default_nettype none
module rsm_board (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Pull-down request
	input wire logic go,
	input wire logic [9:0] len,
	// Pin
	input wire logic dut_oe,
	input wire logic dut_out,
	output logic pin
);
	logic [9:0] cnt;
	// Holds the pin low during power-up, then for len cycles per request
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			cnt <= 10'h003;
		else if (go)
			cnt <= len;
		else if (cnt != 10'h000)
			cnt <= cnt - 10'h001;
	end
	// Wired level with weak pull-up
	assign pin = !(cnt != 10'h000 || (dut_oe && !dut_out));
endmodule : rsm_board
`default_nettype wire

// ---- testbench/reset_sequence_manager_tb.sv ----
// Self-checking bench for the reset sequencer
`timescale 1ns/10ps
`default_nettype none
module reset_sequence_manager_tb;
	import rsm_pkg::*;
	localparam int DL = 300;
	logic clk = 1'b0, arst_n = 1'b0, opt_long_delay = 1'b0, opt_lvd_enable = 1'b1, lvd_below = 1'b0;
	logic dog_underflow = 1'b0, aux_cmp_supply = 1'b0, aux_cmp_sense = 1'b0, aux_source_select = 1'b0;
	logic aux_irq_enable = 1'b0, flag_wr = 1'b0, irq_ack = 1'b0, go = 1'b0, wd = 1'b0, lv = 1'b0;
	logic [7:0] flag_wdata = 8'h00;
	logic [2:0] opt_clk_src = 3'h0;
	rsm_thresh_e opt_lvd_thresh = RSM_TH_LOW;
	logic pin, rst_pin_out, rst_pin_oe, dog_reset_flag, lowv_reset_flag, cpu_reset, osc_run;
	logic aux_detect_flag, vec_fetch, sequencing;
	logic [7:0] integrity_ctrl_status;
	logic [15:0] vec_addr;
	logic [1:0] lvd_thresh_sel;
	logic [2:0] osc_mode;
	logic [15:0] run = 16'h0000;
	logic [17:0] note;
	logic [17:0] notes[$];
	logic [31:0] r = 32'h000080C2;
	int miscompares = 0, total_checks = 0;
	// ----
	// Design, board and clock
	// ----
	rsm_top #(.DELAY_LONG(DL)) dut (.clk, .arst_n, .opt_long_delay, .opt_lvd_enable, .opt_lvd_thresh, .opt_clk_src,
		.rst_pin_in(pin), .rst_pin_out, .rst_pin_oe, .lvd_below, .dog_underflow, .aux_cmp_supply, .aux_cmp_sense,
		.aux_source_select, .aux_irq_enable, .flag_wr, .flag_wdata, .irq_ack, .aux_detect_flag, .lowv_reset_flag,
		.dog_reset_flag, .integrity_ctrl_status, .aux_irq(), .cpu_reset, .vec_fetch, .vec_addr, .osc_run,
		.lvd_thresh_sel, .osc_mode, .sequencing);
	rsm_board board (.clk, .arst_n, .go, .len(10'h014), .dut_oe(rst_pin_oe), .dut_out(rst_pin_out), .pin);
	always #20 clk = ~clk;
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction : xs
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		total_checks++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic close_out();
		if (miscompares == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out
	task automatic settle();
		for (int i = 0; i < 3000 && cpu_reset !== 1'b0; i++) @(posedge clk);
		chk("released", 16'(cpu_reset), 16'h0000);
		repeat (3) @(posedge clk);
	endtask : settle
	// One reset source: 0 watchdog, 1 pin, 2 low voltage, 3 watchdog again mid-delay
	task automatic fire(input int k);
		int m;
		m = (opt_long_delay ? DL : RSM_DELAY_SHORT) + (k == 2 ? 590 : k == 3 ? 1000 : RSM_PULSE_CYCLES - 4);
		wd = k == 2 ? 1'b0 : wd | (k != 1);
		lv = lv | (k == 2);
		notes.push_back({lv, wd, 16'(m)});
		@(posedge clk);
		dog_underflow <= k == 0 || k == 3;
		go <= k == 1;
		lvd_below <= k == 2;
		@(posedge clk);
		dog_underflow <= 1'b0;
		go <= 1'b0;
		if (k >= 2) repeat (600) @(posedge clk);
		dog_underflow <= k == 3;
		lvd_below <= 1'b0;
		@(posedge clk);
		dog_underflow <= 1'b0;
		repeat (4) @(posedge clk);
		settle();
		r = xs(r);
		flag_wr <= 1'b1;
		flag_wdata <= r[7:0];
		wd &= r[RSM_BIT_WDRF];
		lv &= r[RSM_BIT_LVRF];
		@(posedge clk);
		flag_wr <= 1'b0;
	endtask : fire
	// Compares each pull-down against the oldest note
	always @(posedge clk) begin
		if (rst_pin_oe === 1'b1)
			run <= run + 16'h0001;
		else if (run != 16'h0000) begin
			note = notes.pop_front();
			chk("low_len", 16'(run >= note[15:0]), 16'h0001);
			chk("dog_flag", 16'(dog_reset_flag), 16'(note[16]));
			chk("lowv_flag", 16'(lowv_reset_flag), 16'(note[17]));
			chk("fetch", 16'(vec_fetch), 16'h0001);
			chk("vec_addr", vec_addr, RSM_VEC_HI_ADDR);
			chk("sequencing", 16'(sequencing), 16'h0001);
			run <= 16'h0000;
		end
	end
	// Stimulus
	initial begin
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		notes.push_back({2'h0, 16'(RSM_PULSE_CYCLES - 4 + RSM_DELAY_SHORT)});
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			opt_clk_src <= 3'(i);
			opt_lvd_thresh <= rsm_thresh_e'(i[1:0]);
			@(negedge clk);
			chk("osc_mode", 16'(osc_mode), 16'(i > 5 ? 0 : i));
			chk("thresh", 16'(lvd_thresh_sel), 16'(i[1:0] == 2'h3 ? 2 : i[1:0]));
			chk("osc_run", 16'(osc_run), 16'h0001);
		end
		settle();
		for (int d = 0; d < 2; d++) begin
			opt_long_delay <= d[0];
			for (int k = 0; k < 4; k++) fire(k);
		end
		repeat (60) begin
			r = xs(r);
			@(posedge clk);
			{aux_cmp_supply, aux_cmp_sense, aux_source_select, irq_ack} <= r[3:0];
			opt_lvd_enable <= r[5] | r[6];
			aux_irq_enable <= r[7] | r[8];
			@(posedge clk);
			irq_ack <= 1'b0;
			repeat (6) @(posedge clk);
			chk("aux_flag", 16'(aux_detect_flag),
				16'(opt_lvd_enable & (aux_source_select ? aux_cmp_sense : aux_cmp_supply)));
			chk("status_src", 16'(integrity_ctrl_status[RSM_BIT_SRC]), 16'(aux_source_select));
		end
		chk("notes_left", 16'(notes.size()), 16'h0000);
		close_out();
	end
	// Watchdog
	initial begin
		#(40 * 20000);
		miscompares++;
		close_out();
	end
endmodule : reset_sequence_manager_tb
`default_nettype wire
